// file: design/cbd_consts.vh
// constants for the card block command decoder
// assumes inclusion by bare name from the decoder source
`ifndef CBD_CONSTS_VH
`define CBD_CONSTS_VH

// command indices handled here
`define CBD_IDX_STOP      6'h0C
`define CBD_IDX_BLKLEN    6'h10
`define CBD_IDX_RD_ONE    6'h11
`define CBD_IDX_RD_MULTI  6'h12
`define CBD_IDX_WR_ONE    6'h18
`define CBD_IDX_WR_MULTI  6'h19
`define CBD_IDX_PROG_CSD  6'h1B
`define CBD_IDX_PROT_SET  6'h1C
`define CBD_IDX_PROT_CLR  6'h1D
`define CBD_IDX_PROT_QRY  6'h1E
`define CBD_IDX_SEC_START 6'h20
`define CBD_IDX_SEC_END   6'h21
`define CBD_IDX_SEC_DROP  6'h22
`define CBD_IDX_GRP_START 6'h23
`define CBD_IDX_GRP_END   6'h24
`define CBD_IDX_GRP_DROP  6'h25
`define CBD_IDX_ERASE     6'h26
`define CBD_IDX_LOCK      6'h2A
// illegal index bounds
`define CBD_IDX_RSV_A     6'h13
`define CBD_IDX_RSV_B     6'h1A
`define CBD_IDX_RSV_C     6'h1F
`define CBD_IDX_OPT_LO    6'h27
`define CBD_IDX_OPT_HI    6'h38
`define CBD_IDX_LOCK_GAP  6'h2A

// response type codes
`define CBD_RESP_NONE     2'h0
`define CBD_RESP_R1       2'h1
`define CBD_RESP_R1B      2'h2

// data sink / source selection
`define CBD_SINK_MEM      2'h0
`define CBD_SINK_CSD      2'h1
`define CBD_SINK_LOCK     2'h2
`define CBD_SINK_PROT     2'h3

// widths and reset values
`define CBD_DATA_W        8
`define CBD_FIFO_D        4
`define CBD_FIFO_AW       2
`define CBD_BLKLEN_RST    32'h00000200
`define CBD_PROT_QRY_LEN  32'h00000004
`define CBD_ONE32         32'h00000001
`define CBD_ZERO32        32'h00000000

`endif

// file: design/cbd_decoder.v
// card block command decoder: command decode, block data path and its fifo
// assumes command fields arrive from logic on CLK, one cycle per command
`timescale 1ns/10ps
`include "cbd_consts.vh"

// small synchronous fifo, flopped ready and valid flags
module cbd_fifo #(
    parameter W  = 8,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          in_valid,
    input  wire [W-1:0]  in_data,
    output wire          in_ready,
    output wire          out_valid,
    output wire [W-1:0]  out_data,
    input  wire          out_ready
);
    localparam [AW:0] DEPTH = D;           // depth at counter width
    localparam [AW:0] ONE   = 1;

    reg  [W-1:0]  mem_q [0:D-1];           // storage words
    reg  [AW-1:0] wp_q;                    // write pointer
    reg  [AW-1:0] rp_q;                    // read pointer
    reg  [AW:0]   cnt_q;                   // words held
    reg           rdy_q;                   // room left
    reg           vld_q;                   // data held
    reg  [AW:0]   cnt_d;
    wire          push;
    wire          pop;

    assign push      = in_valid & rdy_q;
    assign pop       = out_ready & vld_q;
    assign in_ready  = rdy_q;
    assign out_valid = vld_q;
    assign out_data  = mem_q[rp_q];

    // next fill level
    always @* begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + ONE;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - ONE;
        end
    end

    // pointers and flags; flags flopped so the top sees clean levels
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != DEPTH);
            vld_q <= (cnt_d != {(AW+1){1'b0}});
        end
    end

    // storage has no reset; only written words are ever read
    always @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

// Function
// - block length command stores length, short response
// - single read sends one block
// - multi read runs until stop or new read
// - single write accepts one block
// - multi write runs until host stops it
// - card data program takes one block
// - set protection of addressed group, busy
// - clear protection of addressed group, busy
// - protection query returns bits as data
// - record first erase sector
// - record last or single erase sector
// - drop one sector from erase set
// - record first erase group
// - record last erase group
// - drop one group from erase set
// - erase selection, busy until done
// - lock takes data block, busy response
// - lock block uses stored block length
// - stop ends multi transfer, busy response
module cbd_decoder (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire        CMD_VALID,
    input  wire [5:0]  CMD_INDEX,
    input  wire [31:0] CMD_ARG,
    input  wire [4:0]  PROT_GRP_SHIFT,
    input  wire        OP_DONE,
    input  wire        WR_VALID,
    input  wire [7:0]  WR_DATA,
    output wire        WR_READY,
    input  wire        MEM_READY,
    input  wire        RD_READY,
    output reg         RESP_VALID,
    output reg  [1:0]  RESP_TYPE,
    output reg         RESP_ILLEGAL,
    output reg         BUSY,
    output reg         OP_START,
    output reg  [5:0]  OP_CODE,
    output reg  [31:0] OP_ADDR,
    output reg  [31:0] BLOCK_LEN,
    output reg  [1:0]  DATA_SINK,
    output reg         MEM_WE,
    output reg  [7:0]  MEM_WDATA,
    output reg         MEM_RE,
    output reg  [31:0] MEM_ADDR,
    output reg         BLOCK_END,
    output reg  [31:0] ERASE_FIRST,
    output reg  [31:0] ERASE_LAST,
    output reg         ERASE_BY_GROUP
);
    // one-hot transfer states
    localparam [3:0] ST_IDLE = 4'h1;       // no data transfer
    localparam [3:0] ST_RD   = 4'h2;       // sending blocks
    localparam [3:0] ST_WR   = 4'h4;       // receiving blocks
    localparam [3:0] ST_PRG  = 4'h8;       // waiting for busy release

    reg  [3:0]  st_q;                      // transfer state
    reg  [3:0]  st_d;
    reg         multi_q;                   // open-ended transfer
    reg         first_q;                   // next byte is the transfer's first
    reg  [31:0] cnt_q;                     // bytes done in block
    reg  [31:0] xlen_q;                    // length of this transfer's blocks
    wire        f_vld;                     // fifo head valid
    wire [7:0]  f_data;                    // fifo head byte
    wire        f_pop;                     // consume fifo head
    wire        rd_step;                   // one read byte issued
    wire        step;                      // any byte moved
    wire        last;                      // byte ends the block
    wire        cmd;                       // command accepted
    wire        ill;                       // index is illegal
    wire [1:0]  rtype;                     // response for index

    // illegal: reserved, not applicable, optional unsupported
    function is_illegal;
        input [5:0] idx;
        begin
            is_illegal = (idx == `CBD_IDX_RSV_A) || (idx == `CBD_IDX_RSV_B) ||
                         (idx == `CBD_IDX_RSV_C) ||
                         ((idx >= `CBD_IDX_OPT_LO) && (idx <= `CBD_IDX_OPT_HI) &&
                          (idx != `CBD_IDX_LOCK_GAP));
        end
    endfunction

    // response type; none means the index belongs to other logic
    function [1:0] resp_of;
        input [5:0] idx;
        begin
            case (idx)
                `CBD_IDX_STOP, `CBD_IDX_PROT_SET, `CBD_IDX_PROT_CLR,
                `CBD_IDX_ERASE, `CBD_IDX_LOCK:
                    resp_of = `CBD_RESP_R1B;
                `CBD_IDX_BLKLEN, `CBD_IDX_RD_ONE, `CBD_IDX_RD_MULTI,
                `CBD_IDX_WR_ONE, `CBD_IDX_WR_MULTI, `CBD_IDX_PROG_CSD,
                `CBD_IDX_PROT_QRY, `CBD_IDX_SEC_START, `CBD_IDX_SEC_END,
                `CBD_IDX_SEC_DROP, `CBD_IDX_GRP_START, `CBD_IDX_GRP_END,
                `CBD_IDX_GRP_DROP:
                    resp_of = `CBD_RESP_R1;
                default:
                    resp_of = `CBD_RESP_NONE;
            endcase
        end
    endfunction

    // host write bytes buffered; memory side may stall the drain
    cbd_fifo #(
        .W  (`CBD_DATA_W),
        .D  (`CBD_FIFO_D),
        .AW (`CBD_FIFO_AW)
    ) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (WR_VALID),
        .in_data   (WR_DATA),
        .in_ready  (WR_READY),
        .out_valid (f_vld),
        .out_data  (f_data),
        .out_ready (f_pop)
    );

    // commands are refused while busy; keeps erase atomic, and lock only once its data block is in
    assign cmd     = CMD_VALID & ~BUSY;
    assign ill     = is_illegal(CMD_INDEX);
    assign rtype   = resp_of(CMD_INDEX);
    assign f_pop   = (st_q == ST_WR) & f_vld & MEM_READY & ~cmd;
    assign rd_step = (st_q == ST_RD) & RD_READY & ~cmd;
    assign step    = f_pop | rd_step;
    // zero length treated as one byte so a block always ends
    assign last    = ((cnt_q + `CBD_ONE32) >= xlen_q);

    // next transfer state
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                st_d = ST_IDLE;
            end
            ST_RD, ST_WR: begin
                if (step && last && !multi_q) begin
                    // lock data is followed by programming busy
                    st_d = (DATA_SINK == `CBD_SINK_LOCK) ? ST_PRG : ST_IDLE;
                end
            end
            ST_PRG: begin
                if (OP_DONE) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (cmd && !ill) begin
            case (CMD_INDEX)
                `CBD_IDX_STOP: begin
                    // a stopped write still has to program
                    st_d = (st_q == ST_WR) ? ST_PRG : ST_IDLE;
                end
                `CBD_IDX_RD_ONE, `CBD_IDX_RD_MULTI, `CBD_IDX_PROT_QRY: begin
                    st_d = ST_RD;
                end
                `CBD_IDX_WR_ONE, `CBD_IDX_WR_MULTI, `CBD_IDX_PROG_CSD, `CBD_IDX_LOCK: begin
                    st_d = ST_WR;
                end
                `CBD_IDX_PROT_SET, `CBD_IDX_PROT_CLR, `CBD_IDX_ERASE: begin
                    st_d = ST_PRG;
                end
                default: begin
                    st_d = st_d;
                end
            endcase
        end
    end

    // state, busy and command response
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q         <= ST_IDLE;
            BUSY         <= 1'b0;
            RESP_VALID   <= 1'b0;
            RESP_TYPE    <= `CBD_RESP_NONE;
            RESP_ILLEGAL <= 1'b0;
            OP_START     <= 1'b0;
            OP_CODE      <= 6'h00;
            OP_ADDR      <= `CBD_ZERO32;
        end else begin
            st_q         <= st_d;
            BUSY         <= (st_d == ST_PRG);
            RESP_VALID   <= cmd & (ill | (rtype != `CBD_RESP_NONE));
            RESP_TYPE    <= (cmd & ~ill) ? rtype : `CBD_RESP_NONE;
            RESP_ILLEGAL <= cmd & ill;
            OP_START     <= cmd & ~ill & (rtype != `CBD_RESP_NONE);
            if (cmd && !ill) begin
                OP_CODE <= CMD_INDEX;
                case (CMD_INDEX)
                    `CBD_IDX_PROT_SET, `CBD_IDX_PROT_CLR: begin
                        // group number from address and group size
                        OP_ADDR <= CMD_ARG >> PROT_GRP_SHIFT;
                    end
                    `CBD_IDX_PROG_CSD, `CBD_IDX_ERASE, `CBD_IDX_LOCK, `CBD_IDX_STOP: begin
                        OP_ADDR <= `CBD_ZERO32;
                    end
                    default: begin
                        OP_ADDR <= CMD_ARG;
                    end
                endcase
            end
        end
    end

    // block length, transfer setup and erase selection
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BLOCK_LEN      <= `CBD_BLKLEN_RST;
            xlen_q         <= `CBD_BLKLEN_RST;
            multi_q        <= 1'b0;
            DATA_SINK      <= `CBD_SINK_MEM;
            ERASE_FIRST    <= `CBD_ZERO32;
            ERASE_LAST     <= `CBD_ZERO32;
            ERASE_BY_GROUP <= 1'b0;
        end else if (cmd && !ill) begin
            case (CMD_INDEX)
                `CBD_IDX_BLKLEN: begin
                    BLOCK_LEN <= CMD_ARG;
                end
                `CBD_IDX_RD_ONE, `CBD_IDX_WR_ONE: begin
                    xlen_q    <= BLOCK_LEN;
                    multi_q   <= 1'b0;
                    DATA_SINK <= `CBD_SINK_MEM;
                end
                `CBD_IDX_RD_MULTI, `CBD_IDX_WR_MULTI: begin
                    xlen_q    <= BLOCK_LEN;
                    multi_q   <= 1'b1;
                    DATA_SINK <= `CBD_SINK_MEM;
                end
                `CBD_IDX_PROG_CSD: begin
                    xlen_q    <= BLOCK_LEN;
                    multi_q   <= 1'b0;
                    DATA_SINK <= `CBD_SINK_CSD;
                end
                `CBD_IDX_LOCK: begin
                    xlen_q    <= BLOCK_LEN;
                    multi_q   <= 1'b0;
                    DATA_SINK <= `CBD_SINK_LOCK;
                end
                `CBD_IDX_PROT_QRY: begin
                    // protection bits go out as one fixed word
                    xlen_q    <= `CBD_PROT_QRY_LEN;
                    multi_q   <= 1'b0;
                    DATA_SINK <= `CBD_SINK_PROT;
                end
                `CBD_IDX_SEC_START: begin
                    ERASE_FIRST    <= CMD_ARG;
                    ERASE_LAST     <= CMD_ARG;
                    ERASE_BY_GROUP <= 1'b0;
                end
                `CBD_IDX_SEC_END: begin
                    ERASE_LAST <= CMD_ARG;
                end
                `CBD_IDX_GRP_START: begin
                    ERASE_FIRST    <= CMD_ARG;
                    ERASE_LAST     <= CMD_ARG;
                    ERASE_BY_GROUP <= 1'b1;
                end
                `CBD_IDX_GRP_END: begin
                    ERASE_LAST <= CMD_ARG;
                end
                default: begin
                    // drop commands reach the erase engine by OP_START
                    multi_q <= multi_q;
                end
            endcase
        end
    end

    // byte stream: counts bytes, marks block ends, steps the address
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q     <= `CBD_ZERO32;
            first_q   <= 1'b1;
            MEM_WE    <= 1'b0;
            MEM_WDATA <= 8'h00;
            MEM_RE    <= 1'b0;
            MEM_ADDR  <= `CBD_ZERO32;
            BLOCK_END <= 1'b0;
        end else begin
            MEM_WE    <= f_pop;
            MEM_RE    <= rd_step;
            BLOCK_END <= step & last;
            if (f_pop) begin
                MEM_WDATA <= f_data;
            end
            if (cmd && !ill && ((st_d == ST_RD) || (st_d == ST_WR))) begin
                // a new read restarts the stream at the new address
                cnt_q    <= `CBD_ZERO32;
                first_q  <= 1'b1;
                MEM_ADDR <= ((CMD_INDEX == `CBD_IDX_PROG_CSD) || (CMD_INDEX == `CBD_IDX_LOCK)) ?
                            `CBD_ZERO32 : CMD_ARG;
            end else if (step) begin
                cnt_q <= last ? `CBD_ZERO32 : (cnt_q + `CBD_ONE32);
                first_q <= 1'b0;
                if (!first_q) begin
                    // first byte uses the command address; a flag, since stalls gap the strobes
                    MEM_ADDR <= MEM_ADDR + `CBD_ONE32;
                end
            end
        end
    end
endmodule

// file: test/cbd_host_model.sv
// host side model: write byte source, completion pulses, memory and read pacing
// assumes the bench raises quota to release bytes and slow to stretch every wait
`timescale 1ns/10ps
module cbd_host_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       slow,
    input  wire [7:0] quota,
    input  wire       busy,
    input  wire       wr_ready,
    output reg        wr_valid,
    output reg  [7:0] wr_data,
    output reg        op_done,
    output reg        mem_ready,
    output reg        rd_ready
);
    reg  [7:0] sent_q;                                    // bytes handed over so far
    reg  [4:0] wait_q;                                    // cycles spent busy
    wire [7:0] sent_d = sent_q + {7'h00, wr_valid & wr_ready};
    // byte handshake, pacing and completion in one process
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sent_q    <= 8'h00;
            wait_q    <= 5'h00;
            wr_valid  <= 1'b0;
            wr_data   <= 8'h00;
            op_done   <= 1'b0;
            mem_ready <= 1'b0;
            rd_ready  <= 1'b0;
        end else begin
            sent_q    <= sent_d;
            // slow: ready only every other cycle
            mem_ready <= !slow || !mem_ready;
            rd_ready  <= !slow || !rd_ready;
            // a byte stays put until taken; idle data keeps changing so nothing stale passes
            if (!wr_valid || wr_ready) begin
                wr_valid <= sent_d < quota;
                wr_data  <= (sent_d < quota) ? 8'hA0 + sent_d : ~wr_data;
            end
            // completion after a short or a long programming time
            op_done <= busy && !op_done && wait_q == (slow ? 5'h0F : 5'h02);
            wait_q  <= (busy && !op_done) ? wait_q + 5'h01 : 5'h00;
        end
    end
endmodule

// file: test/cbd_decoder_properties.sv
// timing checker for the card block command decoder
// assumes it is bound to the decoder and sees its ports only
`timescale 1ns/10ps
module cbd_decoder_checker (
    input logic        CLK,
    input logic        RST_N,
    input logic        CMD_VALID,
    input logic [5:0]  CMD_INDEX,
    input logic [31:0] CMD_ARG,
    input logic [4:0]  PROT_GRP_SHIFT,
    input logic        OP_DONE,
    input logic        BUSY,
    input logic        RESP_VALID,
    input logic [1:0]  RESP_TYPE,
    input logic        RESP_ILLEGAL,
    input logic        OP_START,
    input logic [5:0]  OP_CODE,
    input logic [31:0] OP_ADDR,
    input logic [31:0] BLOCK_LEN,
    input logic [31:0] ERASE_FIRST,
    input logic [31:0] ERASE_LAST
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // commands count only while BUSY is low
    wire taken = CMD_VALID && !BUSY;
    // reserved, not applicable and unsupported indices
    wire bad_idx = CMD_INDEX == 6'h13 || CMD_INDEX == 6'h1A || CMD_INDEX == 6'h1F ||
                   (CMD_INDEX >= 6'h27 && CMD_INDEX <= 6'h38 && CMD_INDEX != 6'h2A);
    // data transfers with a plain short answer
    wire xfer = CMD_INDEX inside {6'h11, 6'h12, 6'h18, 6'h19, 6'h1B, 6'h1E};
    property p_blklen;
        taken && CMD_INDEX == 6'h10 |=> RESP_VALID && RESP_TYPE == 2'h1 && BLOCK_LEN == $past(CMD_ARG);
    endproperty
    a_blklen: assert property (p_blklen) else $error("block length not stored");
    property p_blklen_hold;
        !(taken && CMD_INDEX == 6'h10) |=> $stable(BLOCK_LEN);
    endproperty
    a_blklen_hold: assert property (p_blklen_hold) else $error("block length moved");
    property p_xfer;
        taken && xfer |=> OP_START && RESP_TYPE == 2'h1 && OP_CODE == $past(CMD_INDEX) &&
            OP_ADDR == ($past(CMD_INDEX) == 6'h1B ? 32'h0 : $past(CMD_ARG));
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer start wrong");
    property p_prot;
        taken && (CMD_INDEX == 6'h1C || CMD_INDEX == 6'h1D) |=>
            BUSY && RESP_TYPE == 2'h2 && OP_ADDR == $past(CMD_ARG) >> $past(PROT_GRP_SHIFT);
    endproperty
    a_prot: assert property (p_prot) else $error("protection group wrong");
    property p_erase;
        taken && CMD_INDEX == 6'h26 |=> BUSY && RESP_TYPE == 2'h2 && OP_ADDR == 32'h0;
    endproperty
    a_erase: assert property (p_erase) else $error("erase start wrong");
    property p_release;
        BUSY && OP_DONE |=> !BUSY;
    endproperty
    a_release: assert property (p_release) else $error("busy held after done");
    property p_tag;
        taken && (CMD_INDEX == 6'h20 || CMD_INDEX == 6'h23) |=>
            ERASE_FIRST == $past(CMD_ARG) ##1 (ERASE_LAST == ERASE_FIRST) [*1];
    endproperty
    a_tag: assert property (p_tag) else $error("erase start tag wrong");
    property p_illegal;
        taken && bad_idx |=> RESP_VALID && RESP_ILLEGAL && !OP_START && $stable(BLOCK_LEN);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal index accepted");
    property p_stop;
        taken && CMD_INDEX == 6'h0C |=> RESP_VALID && RESP_TYPE == 2'h2 && OP_CODE == 6'h0C;
    endproperty
    a_stop: assert property (p_stop) else $error("stop answer wrong");
endmodule
bind cbd_decoder cbd_decoder_checker u_chk (.*);

// file: test/cbd_decoder_test.sv
// self-checking bench for the card block command decoder
// assumes the host model paces bytes and ends every busy period
`timescale 1ns/10ps
module cbd_decoder_test;
    typedef struct {logic [5:0] idx; logic [31:0] arg; logic rv; logic [1:0] typ; logic ill; logic [31:0] adr;} cbd_row_t;
    cbd_row_t    rows[$];                                // ordinary command cases
    logic        CLK = 1'b0, RST_N = 1'b0, CMD_VALID = 1'b0, SLOW = 1'b0, saw_busy = 1'b0;
    logic        OP_DONE, WR_VALID, WR_READY, MEM_READY, RD_READY, RESP_VALID, RESP_ILLEGAL, BUSY;
    logic        OP_START, MEM_WE, MEM_RE, BLOCK_END, ERASE_BY_GROUP;
    logic [5:0]  CMD_INDEX = 6'h00, OP_CODE;
    logic [7:0]  QUOTA = 8'h00, WR_DATA, MEM_WDATA;
    logic [1:0]  RESP_TYPE, DATA_SINK;
    logic [31:0] CMD_ARG = 32'h0, wa = 32'h0, ra = 32'h0, OP_ADDR, BLOCK_LEN, MEM_ADDR, ERASE_FIRST, ERASE_LAST;
    int          errors = 0, n_checks = 0, n_we = 0, n_re = 0, n_end = 0, m, e, t;
    logic [5:0]  wi[3] = '{6'h18, 6'h1B, 6'h2A};         // write kinds: memory, card data, lock
    cbd_decoder DUT (.PROT_GRP_SHIFT(5'h04), .*);
    cbd_host_model u_host (.clk(CLK), .rst_n(RST_N), .slow(SLOW), .quota(QUOTA), .busy(BUSY),
        .wr_ready(WR_READY), .wr_valid(WR_VALID), .wr_data(WR_DATA), .op_done(OP_DONE),
        .mem_ready(MEM_READY), .rd_ready(RD_READY));
    // 200 MHz clock
    initial forever #2.5 CLK = ~CLK;
    // counts a comparison, true on mismatch
    function automatic bit ck(input bit ok);
        n_checks++;
        return !ok;
    endfunction
    task automatic fail(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        errors++;
    endtask
    task automatic stop_test();
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one command pulse; returns once its answer has landed
    task automatic cmd(input logic [5:0] i, input logic [31:0] a);
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD_INDEX <= i;
        CMD_ARG   <= a;
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        #1;
    endtask
    task automatic idle();
        for (int i = 0; i < 100 && BUSY !== 1'b0; i++) @(posedge CLK);
        #1;
    endtask
    // byte monitor: each strobe compared as it goes by, data follows the model's sequence
    always @(posedge CLK) begin
        if (MEM_WE === 1'b1) begin
            if (ck(MEM_WDATA === 8'hA0 + n_we[7:0] && MEM_ADDR === wa)) fail("write byte");
            n_we++;
            wa++;
        end
        if (MEM_RE === 1'b1) begin
            if (ck(MEM_ADDR === ra)) fail("read address");
            n_re++;
            ra++;
        end
        n_end += (BLOCK_END === 1'b1);
        saw_busy |= (BUSY === 1'b1);
    end
    // hang guard, far beyond the several hundred cycles the run needs
    initial begin
        #100000;
        fail("watchdog");
        stop_test();
    end
    initial begin
        rows = '{'{6'h0C, 32'hFFFF, 1'b1, 2'h2, 1'b0, 32'h0},   // idle stop
            '{6'h10, 32'h4, 1'b1, 2'h1, 1'b0, 32'h4},
            '{6'h1C, 32'h1234, 1'b1, 2'h2, 1'b0, 32'h123},
            '{6'h1D, 32'h50, 1'b1, 2'h2, 1'b0, 32'h5},
            '{6'h26, 32'hFFFF, 1'b1, 2'h2, 1'b0, 32'h0},
            '{6'h20, 32'h100, 1'b1, 2'h1, 1'b0, 32'h100},
            '{6'h21, 32'h180, 1'b1, 2'h1, 1'b0, 32'h180},
            '{6'h22, 32'h140, 1'b1, 2'h1, 1'b0, 32'h140},
            '{6'h25, 32'h41, 1'b1, 2'h1, 1'b0, 32'h41},
            '{6'h23, 32'h40, 1'b1, 2'h1, 1'b0, 32'h40},
            '{6'h24, 32'h47, 1'b1, 2'h1, 1'b0, 32'h47},
            '{6'h13, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47}, '{6'h1A, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47},
            '{6'h1F, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47}, '{6'h27, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47},
            '{6'h29, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47}, '{6'h2B, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47},
            '{6'h38, 32'h9, 1'b1, 2'h0, 1'b1, 32'h47},
            '{6'h00, 32'h9, 1'b0, 2'h0, 1'b0, 32'h47}, '{6'h3F, 32'h9, 1'b0, 2'h0, 1'b0, 32'h47}};
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        foreach (rows[r]) begin
            cmd(rows[r].idx, rows[r].arg);
            if (ck(RESP_VALID === rows[r].rv)) fail("response presence");
            if (rows[r].rv && ck(RESP_TYPE === rows[r].typ && RESP_ILLEGAL === rows[r].ill &&
                OP_START === !rows[r].ill && OP_ADDR === rows[r].adr)) fail("response fields");
            idle();
            if (ck(BUSY === 1'b0)) fail("busy stuck");
        end
        if (ck(BLOCK_LEN === 32'h4 && ERASE_FIRST === 32'h40 && ERASE_LAST === 32'h47 && ERASE_BY_GROUP === 1'b1))
            fail("stored length or erase range");
        // one block each for memory, card data and lock writes; the middle one stalls memory
        for (int k = 0; k < 3; k++) begin
            SLOW <= k[0];
            wa = (k == 0) ? 32'h1000 : 32'h0;
            m = n_we;
            e = n_end;
            saw_busy = 1'b0;
            cmd(wi[k], 32'h1000);
            QUOTA <= QUOTA + 8'h04;  // host sends the block of the length it set
            for (t = 0; t < 300 && n_we < m + 4; t++) @(posedge CLK);
            repeat (30) @(posedge CLK);
            if (ck(n_we === m + 4 && n_end === e + 1)) fail("write block size");
            if (ck(DATA_SINK === 2'(k) && saw_busy === (k == 2))) fail("write sink or busy");
        end
        // fill the buffer with no transfer open until it refuses, then drain it in a stream
        SLOW <= 1'b0;
        m = n_we;
        QUOTA <= QUOTA + 8'h05;
        repeat (20) @(posedge CLK);
        #1;
        if (ck(WR_READY === 1'b0 && n_we === m)) fail("buffer not full or leaked");
        wa = 32'h2000;
        e = n_end;
        cmd(6'h19, 32'h2000);
        QUOTA <= QUOTA + 8'h03;
        for (t = 0; t < 300 && n_we < m + 8; t++) @(posedge CLK);
        saw_busy = 1'b0;
        cmd(6'h0C, 32'h0);  // host closes the stream
        idle();
        if (ck(n_we === m + 8 && n_end === e + 2 && saw_busy === 1'b1)) fail("stream write");
        // single read, protection query with slow reads, then a stream read stopped midway
        for (int k = 0; k < 3; k++) begin
            SLOW <= k[0];
            ra = (k == 0) ? 32'h300 : 32'h10;
            m = n_re;
            e = n_end;
            cmd(k == 0 ? 6'h11 : (k == 1 ? 6'h1E : 6'h12), ra);
            for (t = 0; t < 200 && n_re < m + 10; t++) @(posedge CLK);
            if (k == 2) begin
                cmd(6'h0C, 32'h0);
                repeat (2) @(posedge CLK);
                m = n_re;
                repeat (20) @(posedge CLK);
                if (ck(n_re === m && BUSY === 1'b0 && n_end >= e + 2)) fail("stream read stop");
            end else if (ck(n_re === m + 4 && n_end === e + 1 && DATA_SINK === (k == 1 ? 2'h3 : 2'h0)))
                fail("read block");
        end
        // reset in the middle of a busy erase
        SLOW <= 1'b1;
        cmd(6'h26, 32'h0);
        @(posedge CLK);
        RST_N <= 1'b0;
        QUOTA <= 8'h00;
        repeat (2) @(posedge CLK);
        #1;
        if (ck(BUSY === 1'b0 && BLOCK_LEN === 32'h200 && WR_READY === 1'b1 && RESP_VALID === 1'b0))
            fail("reset values");
        @(posedge CLK);
        RST_N <= 1'b1;
        cmd(6'h10, 32'h8);
        if (ck(BLOCK_LEN === 32'h8 && RESP_TYPE === 2'h1)) fail("length after reset");
        stop_test();
    end
endmodule
